// ===== rtl/t3c_control.sv
/*
 * third general-purpose 16-bit timer: control register, clock source,
 * gating, prescaling, idle halt, wide-pairing override and the count.
 * assumes an apb master on mclk, pins asynchronous, and pairing and idle
 * levels coming from logic on mclk.
 */
`include "t3c_defines.svh"
module t3c_control (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // system levels on mclk
  input  wire logic        cpu_idle,
  input  wire logic        pair_as_wide_timer,
  // pins
  input  wire logic        external_timer_clock_pin,
  input  wire logic        gate_pin,
  // timer outputs
  output logic      [15:0] timer_count,
  output logic             rollover,
  output logic             wide_idle_halt
);
  import t3c_pkg::*;

  // ===========================================================
  // apb decode
  logic        acc;        // access phase
  logic        setup;      // setup phase
  logic        hit_ctrl;   // control register selected
  logic        hit_cnt;    // count register selected
  logic        mapped;     // any register selected
  logic        wr_ctrl;    // control write takes effect
  logic        wr_cnt;     // count write takes effect

  assign acc      = psel && penable;
  assign setup    = psel && !penable;
  assign hit_ctrl = (paddr == `T3C_OFS_CONTROL);
  assign hit_cnt  = (paddr == `T3C_OFS_COUNT);
  assign mapped   = hit_ctrl || hit_cnt;
  assign wr_ctrl  = acc && pwrite && hit_ctrl;
  assign wr_cnt   = acc && pwrite && hit_cnt;
  assign pready   = 1'b1;                    // zero wait states
  assign pslverr  = acc && !mapped;          // unmapped answers error

  // ===========================================================
  // control register storage
  logic [15:0] ctrl_reg;    // implemented bits only, rest read 0
  t3c_ctrl_s   ctrl;        // decoded fields

  // one driver for the whole struct, so no field is driven twice
  assign ctrl = '{run       : ctrl_reg[`T3C_BIT_RUN],
                  stop_idle : ctrl_reg[`T3C_BIT_SIDL],
                  gate_en   : ctrl_reg[`T3C_BIT_GATE],
                  ps        : t3c_prescale_e'(ctrl_reg[`T3C_BIT_PS_HI:`T3C_BIT_PS_LO]),
                  cs        : ctrl_reg[`T3C_BIT_CS]};

  // write only the documented bits; others stay zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `T3C_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= pwdata[15:0] & `T3C_CTRL_WMASK;
    end
  end

  // ===========================================================
  // read data, captured in setup so the output comes from a flop
  logic [31:0] next_prdata;  // selected read word

  assign next_prdata = hit_ctrl ? {16'h0000, ctrl_reg}
                     : hit_cnt  ? {16'h0000, timer_count}
                     : 32'h0000_0000;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end

  // ===========================================================
  // pin synchronisers: two flops before any logic
  logic [1:0] pins_s;       // {gate, ext clock}, synchronised
  logic       ext_d;        // previous synchronised ext clock
  logic       ext_rise;     // one-cycle pulse per pin rising edge
  logic       gate_s;       // synchronised gate level

  t3c_sync #(.W(2)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .d       ({gate_pin, external_timer_clock_pin}),
    .q       (pins_s)
  );

  assign gate_s   = pins_s[1];
  assign ext_rise = pins_s[0] && !ext_d;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ext_d <= 1'b0;
    end else begin
      ext_d <= pins_s[0];
    end
  end

  // ===========================================================
  // input tick: source select, then gating on the internal source
  // limitation: pin edges faster than mclk/2 are lost in the sync
  logic int_tick;      // instruction-clock tick, every mclk
  logic gate_ok;       // gating lets the internal tick pass
  logic in_tick;       // tick into the prescaler
  logic pre_tick;      // tick after prescaling
  logic halted;        // idle halt in force
  logic counting;      // timer allowed to advance
  logic ps_clear;      // restart prescaler

  assign int_tick = 1'b1;
  assign gate_ok  = !ctrl.gate_en || gate_s;
  // gate bit only takes part on the internal source
  assign in_tick  = ctrl.cs ? ext_rise
                            : (int_tick && gate_ok);
  assign halted   = cpu_idle && ctrl.stop_idle;
  // pairing overrides run and the clock path entirely
  assign counting = ctrl.run && !pair_as_wide_timer && !halted;
  // stopping resets the prescaler so a restart begins cleanly
  assign ps_clear = !counting || wr_ctrl;

  t3c_prescale u_prescale (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .clear    (ps_clear),
    .tick_in  (in_tick && counting),
    .sel      (ctrl.ps),
    .tick_out (pre_tick)
  );

  // ===========================================================
  // count register; software write wins over a tick
  logic adv;   // count advances this cycle

  assign adv = counting && pre_tick;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count <= `T3C_COUNT_RESET;
    end else if (wr_cnt) begin
      timer_count <= pwdata[15:0];
    end else if (adv) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // rollover pulse, set on the same edge as the wrap, so high while the count reads zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rollover <= 1'b0;
    end else begin
      rollover <= adv && !wr_cnt && (timer_count == 16'hffff);
    end
  end

  // while paired, this bit governs the wide timer's idle behaviour;
  // software must clear it to keep the wide timer running in idle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wide_idle_halt <= 1'b0;
    end else begin
      wide_idle_halt <= pair_as_wide_timer && cpu_idle && ctrl.stop_idle;
    end
  end

  // ===========================================================
  // checks
  property p_run_stopped;
    @(posedge mclk) disable iff (!reset_n)
      (!ctrl.run && !wr_cnt) |=> (timer_count == $past(timer_count));
  endproperty
  a_run_stopped: assert property (p_run_stopped)
    else $error("count moved with run bit clear");

  property p_run_internal;
    @(posedge mclk) disable iff (!reset_n)
      (counting && !ctrl.cs && !ctrl.gate_en && ctrl.ps == T3C_PS_DIV1 && !wr_cnt && !wr_ctrl)
        |=> (timer_count == $past(timer_count) + 16'h0001);
  endproperty
  a_run_internal: assert property (p_run_internal)
    else $error("internal 1:1 clock did not advance count");

  property p_idle_halt;
    @(posedge mclk) disable iff (!reset_n)
      (cpu_idle && ctrl.stop_idle && !wr_cnt) |=> $stable(timer_count);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("count moved in idle with stop-in-idle set");

  property p_idle_runs;
    @(posedge mclk) disable iff (!reset_n)
      (cpu_idle && !ctrl.stop_idle && ctrl.run && !pair_as_wide_timer) |-> counting;
  endproperty
  a_idle_runs: assert property (p_idle_runs)
    else $error("timer halted in idle with stop-in-idle clear");

  property p_gate_ignored;
    @(posedge mclk) disable iff (!reset_n)
      ctrl.cs |-> (in_tick == ext_rise);
  endproperty
  a_gate_ignored: assert property (p_gate_ignored)
    else $error("gate affected external clock path");

  property p_gate_closed;
    @(posedge mclk) disable iff (!reset_n)
      (!ctrl.cs && ctrl.gate_en && !gate_s && !wr_cnt) |=> $stable(timer_count);
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("gated timer counted with gate low");

  property p_paired_frozen;
    @(posedge mclk) disable iff (!reset_n)
      (pair_as_wide_timer && !wr_cnt) [*2] |-> $stable(timer_count);
  endproperty
  a_paired_frozen: assert property (p_paired_frozen)
    else $error("own controls acted while paired");

  // ===========================================================
  // further checks; most look one edge ahead, the rollover and pair-no-count ones at the same edge;
  // the count checks leave a count write on that edge out of the antecedent
  property p_ctrl_write;
    @(posedge mclk) disable iff (!reset_n)
      wr_ctrl |=> (ctrl_reg == ($past(pwdata[15:0]) & `T3C_CTRL_WMASK));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not keep the implemented bits");

  property p_stop_write;
    @(posedge mclk) disable iff (!reset_n)
      (wr_ctrl && !pwdata[`T3C_BIT_RUN]) |=> !counting;
  endproperty
  a_stop_write: assert property (p_stop_write)
    else $error("timer still counting after run bit cleared");

  // external source: one count per synchronised rising edge at 1:1
  property p_ext_counts;
    @(posedge mclk) disable iff (!reset_n)
      (counting && ctrl.cs && ctrl.ps == T3C_PS_DIV1 && ext_rise && !wr_cnt && !wr_ctrl)
        |=> (timer_count == $past(timer_count) + 16'h0001);
  endproperty
  a_ext_counts: assert property (p_ext_counts)
    else $error("external pin edge did not advance count");

  property p_ext_quiet;
    @(posedge mclk) disable iff (!reset_n)
      (ctrl.cs && !ext_rise && !wr_cnt) |=> $stable(timer_count);
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("count moved without an external pin edge");

  // gate: an open gate passes every internal tick, external ignores it
  property p_gate_open;
    @(posedge mclk) disable iff (!reset_n)
      (counting && !ctrl.cs && ctrl.gate_en && gate_s && ctrl.ps == T3C_PS_DIV1 && !wr_cnt && !wr_ctrl)
        |=> (timer_count == $past(timer_count) + 16'h0001);
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("open gate did not pass the internal tick");

  property p_gate_ext;
    @(posedge mclk) disable iff (!reset_n)
      (counting && ctrl.cs && ctrl.gate_en && !gate_s && ext_rise &&
       ctrl.ps == T3C_PS_DIV1 && !wr_cnt && !wr_ctrl)
        |=> (timer_count == $past(timer_count) + 16'h0001);
  endproperty
  a_gate_ext: assert property (p_gate_ext)
    else $error("closed gate blocked the external clock");

  // wrap pulse and the outputs toward the companion timer
  property p_rollover_zero;
    @(posedge mclk) disable iff (!reset_n)
      rollover |-> (timer_count == 16'h0000);
  endproperty
  a_rollover_zero: assert property (p_rollover_zero)
    else $error("rollover pulse without a wrapped count");

  property p_wide_idle;
    @(posedge mclk) disable iff (!reset_n)
      (pair_as_wide_timer && cpu_idle && ctrl.stop_idle) |=> wide_idle_halt;
  endproperty
  a_wide_idle: assert property (p_wide_idle)
    else $error("paired idle halt not signalled");

  property p_pair_no_count;
    @(posedge mclk) disable iff (!reset_n)
      pair_as_wide_timer |-> !counting;
  endproperty
  a_pair_no_count: assert property (p_pair_no_count)
    else $error("run bit acted while paired");

endmodule

// ===== rtl/t3c_defines.svh
/*
 * constants of the third timer's control block: register offsets, field
 * positions, reset values, prescale limits and timing counts.
 * assumes it is included by bare name from rtl files after the package.
 */
`ifndef T3C_DEFINES_SVH
`define T3C_DEFINES_SVH

// ===========================================================
// register map (byte addresses on apb)
`define T3C_OFS_CONTROL   12'h000
`define T3C_OFS_COUNT     12'h004

// ===========================================================
// control field positions
`define T3C_BIT_RUN       15
`define T3C_BIT_SIDL      13
`define T3C_BIT_GATE      6
`define T3C_BIT_PS_HI     5
`define T3C_BIT_PS_LO     4
`define T3C_BIT_CS        1
`define T3C_CTRL_WMASK    16'ha072
`define T3C_CTRL_RESET    16'h0000
`define T3C_COUNT_RESET   16'h0000

// ===========================================================
// prescale terminal counts (divide minus one)
`define T3C_PS_LAST_1     8'h00
`define T3C_PS_LAST_8     8'h07
`define T3C_PS_LAST_64    8'h3f
`define T3C_PS_LAST_256   8'hff

// ===========================================================
// timing: mclk 50 MHz is the instruction clock, i.e. oscillator / 2
`define T3C_MCLK_NS       20
`define T3C_INT_TICK_CYC  1

`endif

// ===== rtl/t3c_pkg.sv
/*
 * types shared by the third timer's control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package t3c_pkg;

  // ===========================================================
  // prescale selections, as coded in the control field
  typedef enum logic [1:0] {
    T3C_PS_DIV1   = 2'b00,
    T3C_PS_DIV8   = 2'b01,
    T3C_PS_DIV64  = 2'b10,
    T3C_PS_DIV256 = 2'b11
  } t3c_prescale_e;

  // ===========================================================
  // decoded control fields
  typedef struct packed {
    logic          run;        // timer_run
    logic          stop_idle;  // stop_in_idle
    logic          gate_en;    // gated_accumulate_enable
    t3c_prescale_e ps;         // input_prescale_select
    logic          cs;         // clock_source_select
  } t3c_ctrl_s;

endpackage

// ===== rtl/t3c_prescale.sv
/*
 * input prescaler of the third timer: 1, 8, 64 or 256 input ticks
 * make one counting tick.
 * assumes tick_in is a one-cycle pulse in the mclk domain.
 */
`include "t3c_defines.svh"
module t3c_prescale (
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   clear,
  input  wire logic                   tick_in,
  input  wire t3c_pkg::t3c_prescale_e sel,
  output logic                        tick_out
);
  import t3c_pkg::*;

  logic [7:0] div_cnt;  // ticks seen since last output
  logic [7:0] last;     // terminal count for the selection

  // ===========================================================
  // terminal count select
  always_comb begin
    case (sel)
      T3C_PS_DIV8:   last = `T3C_PS_LAST_8;
      T3C_PS_DIV64:  last = `T3C_PS_LAST_64;
      T3C_PS_DIV256: last = `T3C_PS_LAST_256;
      default:       last = `T3C_PS_LAST_1;
    endcase
  end

  assign tick_out = tick_in && (div_cnt >= last);

  // ===========================================================
  // divider; >= guards a shrink of sel mid-count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 8'h00;
    end else if (clear || tick_out) begin
      div_cnt <= 8'h00;
    end else if (tick_in) begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ===========================================================
  // helper: ticks accepted since the last output
  logic [8:0] seen;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 9'h000;
    end else if (clear || tick_out) begin
      seen <= 9'h000;
    end else if (tick_in) begin
      seen <= seen + 9'h001;
    end
  end

  property p_prescale_ratio;
    @(posedge mclk) disable iff (!reset_n)
      (tick_out && !$changed(sel) && !$past(clear)) |->
        (seen == ((sel == T3C_PS_DIV256) ? {1'b0, `T3C_PS_LAST_256} :
                  (sel == T3C_PS_DIV64)  ? {1'b0, `T3C_PS_LAST_64}  :
                  (sel == T3C_PS_DIV8)   ? {1'b0, `T3C_PS_LAST_8}   : {1'b0, `T3C_PS_LAST_1}));
  endproperty
  a_prescale_ratio: assert property (p_prescale_ratio)
    else $error("prescaler output not at selected ratio");

endmodule

// ===== rtl/t3c_sync.sv
/*
 * two-flop synchroniser for pin-level inputs.
 * assumes inputs are asynchronous to mclk; only q is read outside.
 */
module t3c_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ===========================================================
  // per-bit flop pair; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta;  // first stage, read by q only
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          meta <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

// ===== tb/t3c_control_tb_top.sv
/*
 * self-checking bench for the third timer's control block.
 * assumes the rtl files and the defines header are compiled first.
 */
`include "t3c_defines.svh"
module t3c_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import t3c_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        mclk     = 1'b0;
  logic        reset_n  = 1'b0;  // active low
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_idle = 1'b0;
  logic        pair     = 1'b0;  // companion's pairing level
  logic        ext_pin  = 1'b0;
  logic        gate_pin = 1'b0;
  logic [15:0] timer_count;
  logic        rollover;
  logic        wide_idle_halt;
  logic        ext_on   = 1'b0;  // pin toggler enable
  logic [2:0]  ph       = 3'h0;
  int          n_errors   = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  logic [31:0] rdv;
  logic        err;
  // ==========================================================
  // clock, pin toggler and hang guard
  always #10 mclk = ~mclk;
  // pin rises once per eight mclk, well inside the sync's reach
  always @(posedge mclk) begin
    if (ext_on) begin
      ph      <= ph + 3'h1;
      ext_pin <= ph[2];
    end
  end
  // cycle ceiling: whole run needs well under 8000 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[ERR] run length expected under 20000 cycles seen %0d", cyc);
      n_errors = n_errors + 1;
      results();
    end
  end
  t3c_control dut (
    .mclk                     (mclk),
    .reset_n                  (reset_n),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .cpu_idle                 (cpu_idle),
    .pair_as_wide_timer       (pair),
    .external_timer_clock_pin (ext_pin),
    .gate_pin                 (gate_pin),
    .timer_count              (timer_count),
    .rollover                 (rollover),
    .wide_idle_halt           (wide_idle_halt)
  );
  // ==========================================================
  // bus and compare tasks
  // one apb transfer, entered just after an edge; an idle edge follows
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdv     = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // range compare; an unknown never passes
  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      $display("[ERR] %s expected %0h..%0h seen %0h", nm, lo, hi, got);
      n_errors++;
    end
  endtask
  // clear count, run with c for w cycles between write edges, stop, read
  task automatic meas(input logic [31:0] c, input int w, output logic [31:0] n);
    apb(1'b1, `T3C_OFS_COUNT, 32'h0000_0000);
    apb(1'b1, `T3C_OFS_CONTROL, c);
    repeat (w - 3) @(posedge mclk);
    apb(1'b1, `T3C_OFS_CONTROL, c & 32'h0000_7fff);
    apb(1'b0, `T3C_OFS_COUNT, 32'h0000_0000);
    n = rdv;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_map();
    apb(1'b0, `T3C_OFS_CONTROL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, 32'h0000_0000, rdv);
    chk("pready", 32'h0000_0001, 32'h0000_0001, {31'h0, pready});
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, 32'h0000_0000, rdv);
    pair <= 1'b1;
    apb(1'b1, `T3C_OFS_CONTROL, 32'hffff_ffff);
    apb(1'b0, `T3C_OFS_CONTROL, 32'h0000_0000);
    chk("ctrl mask", 32'h0000_a072, 32'h0000_a072, rdv);
    chk("paired frozen", 32'h0000_0000, 32'h0000_0000, {16'h0, timer_count});
    apb(1'b1, `T3C_OFS_CONTROL, 32'h0000_0000);
    pair <= 1'b0;
  endtask
  // every prescale code, run then stop
  task automatic t_prescale();
    int          d [4] = '{1, 8, 64, 256};
    logic [31:0] n;
    for (int i = 0; i < 4; i++) begin
      meas(32'h0000_8000 | (i << 4), 4 * d[i] + 2, n);
      chk("prescale count", (4 * d[i] + 2) / d[i] - 1, (4 * d[i] + 2) / d[i], n);
    end
    repeat (20) @(posedge mclk);
    chk("stopped holds", n, n, {16'h0, timer_count});
  endtask
  // gate level on internal clock, then gate ignored on external clock
  task automatic t_gate_ext();
    logic [31:0] n;
    meas(32'h0000_8040, 40, n);
    chk("gate low", 32'h0000_0000, 32'h0000_0000, n);
    gate_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    meas(32'h0000_8040, 40, n);
    chk("gate high", 32'd39, 32'd40, n);
    gate_pin <= 1'b0;
    meas(32'h0000_8002, 40, n);
    chk("ext no edges", 32'h0000_0000, 32'h0000_0000, n);
    ext_on <= 1'b1;
    meas(32'h0000_8042, 66, n);
    chk("ext edges", 32'd6, 32'd9, n);
    ext_on <= 1'b0;
  endtask
  // idle halt, paired idle signal and software clearing it
  task automatic t_idle();
    logic [31:0] n;
    cpu_idle <= 1'b1;
    meas(32'h0000_a000, 40, n);
    chk("idle halt", 32'h0000_0000, 32'h0000_0000, n);
    meas(32'h0000_8000, 40, n);
    chk("idle runs", 32'd39, 32'd40, n);
    pair <= 1'b1;
    meas(32'h0000_8000, 40, n);
    chk("pair run off", 32'h0000_0000, 32'h0000_0000, n);
    apb(1'b1, `T3C_OFS_CONTROL, 32'h0000_2000);
    repeat (2) @(posedge mclk);
    chk("wide halt", 32'h0000_0001, 32'h0000_0001, {31'h0, wide_idle_halt});
    apb(1'b1, `T3C_OFS_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk("wide runs", 32'h0000_0000, 32'h0000_0000, {31'h0, wide_idle_halt});
    pair     <= 1'b0;
    cpu_idle <= 1'b0;
  endtask
  // wrap from ffff to 0000 gives one rollover pulse
  task automatic t_wrap();
    int seen;
    seen = 0;
    apb(1'b1, `T3C_OFS_COUNT, 32'h0000_fffe);
    apb(1'b1, `T3C_OFS_CONTROL, 32'h0000_8000);
    repeat (10) begin
      @(posedge mclk);
      if (rollover === 1'b1) seen++;
    end
    chk("rollover pulses", 32'h0000_0001, 32'h0000_0001, seen);
    apb(1'b1, `T3C_OFS_CONTROL, 32'h0000_0000);
  endtask
  // ==========================================================
  // verdict, the single end of the run
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset_map();
    t_prescale();
    t_gate_ext();
    t_idle();
    t_wrap();
    results();
  end
endmodule
